// ==== src/apap_core.sv ====
// Purpose: audio record conditioning, 4:1 adpcm packing and pwm playback
// Assumes: core clock is the pwm counter clock; samples are two's complement
// Notes:   record and playback run independently; control bits are plain ports
`timescale 1ns/1ps
`include "apap_params.svh"

// Functional notes
// - each pwm pulse is high for a width set by the sample being played.
// - the pulse repetition rate comes from the software sample rate setting.
// - the sample rate setting is honoured anywhere from 8 kHz to 48 kHz.
// - every pwm width and period is counted by one counter at the 48 MHz count rate; the buzzer has its own counter.
// - playback is split into control inputs, a sample fifo, the modulator and a buzzer.
// - the record path hands each conditioned sample on as a 16-bit value to compression.
// - compression turns 16-bit samples into 4-bit codes, a fixed ratio of four to one.
// - the record path applies automatic level control and a noise gate.
// - the record path applies an adjustable volume to the converter output.
module apap_core #(
	parameter int PLAY_DEPTH = 2
) (
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RST_N,
	input  wire logic [15:0] I_RATE_HZ,
	input  wire logic [15:0] I_PLAY_DATA,
	input  wire logic        I_PLAY_VALID,
	output logic             O_PLAY_READY,
	output logic             O_PWM,
	input  wire logic        I_BUZZ_EN,
	input  wire logic [15:0] I_BUZZ_HALF,
	output logic             O_BUZZER,
	input  wire logic [15:0] I_ADC_DATA,
	input  wire logic        I_ADC_VALID,
	output logic             O_ADC_READY,
	input  wire logic [7:0]  I_VOLUME,
	input  wire logic [15:0] I_GATE_LEVEL,
	output logic [15:0]      O_ADPCM_DATA,
	output logic             O_ADPCM_VALID,
	input  wire logic        I_ADPCM_READY,
	output logic [12:0]      O_PERIOD,
	output logic [7:0]       O_ALC_GAIN
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] gain_sat(input logic [15:0] x, input logic [7:0] g);
		logic signed [24:0] p;
		p = $signed(x) * $signed({1'b0, g});
		p = p >>> 7;
		if (p > 25'sd32767) begin
			return 16'h7fff;
		end else if (p < -25'sd32768) begin
			return 16'h8000;
		end
		return p[15:0];
	endfunction

	function automatic logic [15:0] mag16(input logic [15:0] x);
		return x[15] ? ((x == 16'h8000) ? 16'h7fff : 16'(-x)) : x;
	endfunction

	// offset-binary sample times period, top bits kept: width lies in [0, period)
	function automatic logic [12:0] scale(input logic [15:0] s, input logic [12:0] per);
		logic [28:0] p;
		p = {~s[15], s[14:0]} * per;
		return p[28:16];
	endfunction

	// ----------------------------------------
	// rate setting and period divider
	// ----------------------------------------
	apap_pkg::apap_div_st_t div_st_q;
	logic [15:0] rate_sel;
	logic [15:0] rate_q;
	logic [16:0] rem_q;
	logic [25:0] quo_q;
	logic [4:0]  bits_q;
	logic [12:0] period_q;
	logic [16:0] rem_sh;
	logic        q_bit;
	logic [12:0] per_nxt;

	always_comb begin
		rate_sel = I_RATE_HZ;
		if (I_RATE_HZ < `APAP_RATE_MIN_HZ) begin
			rate_sel = `APAP_RATE_MIN_HZ;
		end else if (I_RATE_HZ > `APAP_RATE_MAX_HZ) begin
			rate_sel = `APAP_RATE_MAX_HZ;
		end
		rem_sh = {rem_q[15:0], quo_q[25]};
		q_bit  = (rem_sh >= {1'b0, rate_q});
		// period that stands after this edge: the last divide step hands its quotient over
		per_nxt = (div_st_q == apap_pkg::DIV_RUN && bits_q == 5'h01) ? {quo_q[11:0], q_bit} : period_q;
	end

	// serial divide: a rate change costs 27 cycles, the old period runs on meanwhile
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			div_st_q <= apap_pkg::DIV_IDLE;
			rate_q   <= `APAP_RATE_MIN_HZ;
			rem_q    <= '0;
			quo_q    <= '0;
			bits_q   <= '0;
			period_q <= `APAP_PERIOD_RST;
		end else begin
			case (div_st_q)
				apap_pkg::DIV_IDLE: begin
					if (rate_sel != rate_q) begin
						rate_q   <= rate_sel;
						rem_q    <= '0;
						quo_q    <= `APAP_CNT_HZ;
						bits_q   <= 5'(`APAP_CNT_BITS);
						div_st_q <= apap_pkg::DIV_RUN;
					end
				end
				apap_pkg::DIV_RUN: begin
					rem_q  <= q_bit ? 17'(rem_sh - {1'b0, rate_q}) : rem_sh;
					quo_q  <= {quo_q[24:0], q_bit};
					bits_q <= bits_q - 5'h01;
					if (bits_q == 5'h01) begin
						period_q <= {quo_q[11:0], q_bit};
						div_st_q <= apap_pkg::DIV_IDLE;
					end
				end
				default: div_st_q <= apap_pkg::DIV_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// playback fifo and modulator
	// ----------------------------------------
	logic [15:0] play_data;
	logic        play_valid;
	logic        period_end;
	logic        take;
	logic [12:0] cnt_q;
	logic [12:0] width_q;
	logic        pwm_q;

	apap_fifo2 #(
		.W     (16),
		.DEPTH (PLAY_DEPTH)
	) u_play_fifo (
		.i_clk   (I_CORE_CLK),
		.i_rst_n (I_RST_N),
		.i_valid (I_PLAY_VALID),
		.o_ready (O_PLAY_READY),
		.i_data  (I_PLAY_DATA),
		.o_valid (play_valid),
		.i_ready (take),
		.o_data  (play_data)
	);

	assign period_end = (cnt_q >= period_q - 13'h0001);
	assign take       = period_end;

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= period_end ? 13'h0000 : cnt_q + 13'h0001;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			width_q <= '0;
		end else if (period_end && play_valid) begin
			width_q <= scale(play_data, per_nxt);
		end else if (width_q >= per_nxt) begin
			// a shrinking period pulls the held width under it, so no pulse fills its period
			width_q <= per_nxt - 13'h0001;
		end
	end // width held when no sample is waiting

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			pwm_q <= 1'b0;
		end else begin
			pwm_q <= (cnt_q < width_q);
		end
	end
	assign O_PWM    = pwm_q;
	assign O_PERIOD = period_q;

	// ----------------------------------------
	// piezo buzzer
	// ----------------------------------------
	logic [15:0] buzz_cnt_q;
	logic        buzz_q;

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N || !I_BUZZ_EN) begin
			buzz_cnt_q <= '0;
			buzz_q     <= 1'b0;
		end else if (buzz_cnt_q >= I_BUZZ_HALF) begin
			buzz_cnt_q <= '0;
			buzz_q     <= !buzz_q;
		end else begin
			buzz_cnt_q <= buzz_cnt_q + 16'h0001;
		end
	end
	assign O_BUZZER = buzz_q;

	// ----------------------------------------
	// record conditioning
	// ----------------------------------------
	logic [15:0] vol_s;
	logic [15:0] alc_s;
	logic [15:0] alc_m;
	logic [7:0]  gain_q;
	logic [15:0] rec_q;
	logic        rec_v_q;
	logic        adc_take;
	logic        rec_take;

	assign vol_s    = gain_sat(I_ADC_DATA, I_VOLUME);
	assign alc_s    = gain_sat(vol_s, gain_q);
	assign alc_m    = mag16(alc_s);
	assign adc_take = I_ADC_VALID && O_ADC_READY;
	assign O_ADC_READY = !rec_v_q || rec_take;

	// attack and release both move one step per sample; no hold time by design
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			gain_q <= `APAP_GAIN_UNITY;
		end else if (adc_take) begin
			if (alc_m > `APAP_ALC_TARGET && gain_q > `APAP_GAIN_MIN) begin
				gain_q <= gain_q - 8'h01;
			end else if (alc_m < `APAP_ALC_LOW && gain_q < `APAP_GAIN_UNITY) begin
				gain_q <= gain_q + 8'h01;
			end
		end
	end
	assign O_ALC_GAIN = gain_q;

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			rec_q   <= '0;
			rec_v_q <= 1'b0;
		end else if (adc_take) begin
			rec_q   <= (alc_m < I_GATE_LEVEL) ? 16'h0000 : alc_s;
			rec_v_q <= 1'b1;
		end else if (rec_take) begin
			rec_v_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// 4:1 adpcm: 16-bit sample in, 4-bit code out
	// ----------------------------------------
	logic [3:0]  shift_q;
	logic [15:0] pred_q;
	logic [1:0]  nib_q;
	logic [11:0] pack_q;
	logic        pack_ready;
	logic        pack_push;
	logic signed [16:0] diff;
	logic [16:0] dmag;
	logic [2:0]  code_mag;
	logic [3:0]  code;
	logic signed [17:0] recon;
	logic signed [17:0] pred_n;

	always_comb begin
		diff     = $signed({rec_q[15], rec_q}) - $signed({pred_q[15], pred_q});
		dmag     = diff[16] ? 17'(-diff) : 17'(diff);
		code_mag = ((dmag >> shift_q) > 17'h00007) ? 3'h7 : 3'(dmag >> shift_q);
		code     = {diff[16], code_mag};
		recon    = 18'sd0;
		recon    = 18'(({15'h0000, code_mag} << shift_q) + (18'h00001 << shift_q >> 1));
		pred_n   = diff[16] ? $signed({{2{pred_q[15]}}, pred_q}) - recon
				: $signed({{2{pred_q[15]}}, pred_q}) + recon;
	end

	assign rec_take  = rec_v_q && (nib_q != 2'h3 || pack_ready);
	assign pack_push = rec_v_q && nib_q == 2'h3;

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			shift_q <= `APAP_SHIFT_RST;
			pred_q  <= '0;
			nib_q   <= '0;
			pack_q  <= '0;
		end else if (rec_take) begin
			if (pred_n > 18'sd32767) begin
				pred_q <= 16'h7fff;
			end else if (pred_n < -18'sd32768) begin
				pred_q <= 16'h8000;
			end else begin
				pred_q <= pred_n[15:0];
			end
			if (code_mag >= 3'h4 && shift_q < `APAP_SHIFT_MAX) begin
				shift_q <= shift_q + 4'h1;
			end else if (code_mag < 3'h2 && shift_q > `APAP_SHIFT_MIN) begin
				shift_q <= shift_q - 4'h1;
			end
			pack_q <= {pack_q[7:0], code};
			nib_q  <= nib_q + 2'h1;
		end
	end

	apap_fifo2 #(
		.W     (16),
		.DEPTH (2)
	) u_out_buf (
		.i_clk   (I_CORE_CLK),
		.i_rst_n (I_RST_N),
		.i_valid (pack_push),
		.o_ready (pack_ready),
		.i_data  ({pack_q, code}),
		.o_valid (O_ADPCM_VALID),
		.i_ready (I_ADPCM_READY),
		.o_data  (O_ADPCM_DATA)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	pulse_width_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		period_end && play_valid |=> width_q == scale($past(play_data), $past(per_nxt)))
		else $error("pulse width does not follow sample");
	width_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		period_end && !play_valid && width_q < per_nxt |=> $stable(width_q))
		else $error("width changed with no sample");
	rate_range_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		rate_q >= `APAP_RATE_MIN_HZ && rate_q <= `APAP_RATE_MAX_HZ)
		else $error("rate outside range");
	period_range_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		period_q >= `APAP_PERIOD_MIN && period_q <= `APAP_PERIOD_RST && width_q < period_q)
		else $error("period or width out of range");
	divide_time_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		div_st_q == apap_pkg::DIV_IDLE && rate_sel != rate_q
		|=> div_st_q == apap_pkg::DIV_RUN && bits_q == 5'h1a
		##25 div_st_q == apap_pkg::DIV_RUN && bits_q == 5'h01
		##1 div_st_q == apap_pkg::DIV_IDLE)
		else $error("period divide took wrong time");
	counter_wrap_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		period_end |=> cnt_q == 13'h0000)
		else $error("counter did not wrap");
	noise_gate_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		adc_take && alc_m < I_GATE_LEVEL |=> rec_v_q && rec_q == 16'h0000)
		else $error("gate let sample through");
	pack_ratio_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		pack_push && pack_ready |=> nib_q == 2'h0)
		else $error("word emitted off a four-code boundary");
	buzz_off_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		!I_BUZZ_EN |=> !O_BUZZER)
		else $error("buzzer active while disabled");
endmodule

// ==== include/apap_params.svh ====
// Purpose: constants of the audio pwm / adpcm path
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef APAP_PARAMS_SVH
`define APAP_PARAMS_SVH

// ----------------------------------------
// playback timing
// ----------------------------------------
`define APAP_CNT_HZ      26'd48000000
`define APAP_CNT_BITS    26
`define APAP_RATE_MIN_HZ 16'd8000
`define APAP_RATE_MAX_HZ 16'd48000
`define APAP_PERIOD_BITS 13
`define APAP_PERIOD_RST  13'd6000
`define APAP_PERIOD_MIN  13'd1000

// ----------------------------------------
// record path
// ----------------------------------------
`define APAP_GAIN_UNITY  8'h80
`define APAP_GAIN_MIN    8'h08
`define APAP_ALC_TARGET  16'h6000
`define APAP_ALC_LOW     16'h3000
`define APAP_SHIFT_MIN   4'h4
`define APAP_SHIFT_MAX   4'he
`define APAP_SHIFT_RST   4'h8

`endif

// ==== include/apap_pkg.sv ====
// Purpose: shared types of the audio pwm / adpcm path
// Assumes: nothing
// Notes:   constants live in apap_params.svh
package apap_pkg;
	typedef logic [15:0] apap_sample_t;
	typedef enum logic {DIV_IDLE, DIV_RUN} apap_div_st_t;
endpackage

// ==== src/apap_fifo2.sv ====
// Purpose: small valid/ready buffer in the sample path
// Assumes: one clock, synchronous active-low reset
// Notes:   default depth two, so a stall by the reader loses no word
`timescale 1ns/1ps
module apap_fifo2 #(
	parameter int W     = 16,
	parameter int DEPTH = 2
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_valid,
	output logic              o_ready,
	input  wire logic [W-1:0] i_data,
	output logic              o_valid,
	input  wire logic         i_ready,
	output logic [W-1:0]      o_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;
	logic          push;
	logic          pop;

	assign o_ready = (cnt_q != (AW+1)'(DEPTH));
	assign o_valid = (cnt_q != '0);
	assign o_data  = mem_q[rd_q];
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;

	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wr_q] <= i_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= nxt(wr_q);
			end
			if (pop) begin
				rd_q <= nxt(rd_q);
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	fifo_bound_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(cnt_q <= (AW+1)'(DEPTH)) and (push && !pop |=> cnt_q == $past(cnt_q) + 1'b1))
		else $error("buffer count out of step");
endmodule

// ==== bench/apap_speaker_model.sv ====
// Purpose: speaker and piezo behind the rc filter, seen as pulse measurements
// Assumes: one clock; the pins are sampled at its rising edge
// Notes:   the filter is not modelled, only high-run length and toggle spacing
`timescale 1ns/1ps
module apap_speaker_model (
	input  wire logic i_clk,
	input  wire logic i_pwm,
	input  wire logic i_buzzer,
	output int        o_high_len,
	output int        o_buzz_half
);
	int   run_q  = 0;
	int   gap_q  = 0;
	logic pwm_q  = 1'b0;
	logic buzz_q = 1'b0;

	initial begin
		o_high_len  = 0;
		o_buzz_half = 0;
	end

	// a run is only reported on its falling edge, so a width of zero never updates it
	always @(posedge i_clk) begin
		pwm_q  <= i_pwm;
		buzz_q <= i_buzzer;
		run_q  <= i_pwm ? run_q + 1 : 0;
		if (pwm_q && !i_pwm) begin
			o_high_len <= run_q;
		end
		gap_q <= (i_buzzer !== buzz_q) ? 1 : gap_q + 1;
		if (i_buzzer !== buzz_q) begin
			o_buzz_half <= gap_q;
		end
	end
endmodule

// ==== bench/audio_pwm_adpcm_path_bench.sv ====
// Purpose: self-checking bench of the audio pwm / adpcm path
// Assumes: core clock 10 MHz, treated as the count clock for period figures
// Notes:   table rows for rate and width, hand tests for buffers, record path and reset
`timescale 1ns/1ps
module audio_pwm_adpcm_path_bench;
	logic        clk         = 1'b0;
	logic        rst_n       = 1'b0;
	logic [15:0] rate_hz     = 16'h1f40;
	logic [15:0] play_data   = 16'h0000;
	logic        play_valid  = 1'b0;
	logic        buzz_en     = 1'b0;
	logic [15:0] buzz_half   = 16'h0009;
	logic [15:0] adc_data    = 16'h0000;
	logic        adc_valid   = 1'b0;
	logic [7:0]  volume      = 8'h80;
	logic [15:0] gate_level  = 16'h0000;
	logic        adpcm_ready = 1'b1;
	logic        play_ready, pwm, buzzer, adc_ready, adpcm_valid;
	logic [15:0] adpcm_data;
	logic [15:0] last_word;
	logic [12:0] period;
	logic [7:0]  alc_gain;
	int          high_len, buzz_gap, n;
	int          n_words    = 0;
	int          prev       = 6000;
	int          errors     = 0;
	int          n_compared = 0;

	// rate, sample, expected period, expected high cycles
	localparam logic [63:0] ROWS [6] = '{
		{16'hbb80, 16'h0000, 16'h03e8, 16'h01f4},
		{16'hbb80, 16'h4000, 16'h03e8, 16'h02ee},
		{16'h5dc0, 16'hc000, 16'h07d0, 16'h01f4},
		{16'h3e80, 16'h7fff, 16'h0bb8, 16'h0bb7},
		{16'hea60, 16'h9000, 16'h03e8, 16'h003e},
		{16'h0fa0, 16'h2000, 16'h1770, 16'h0ea6}};

	always #50 clk = ~clk;

	apap_core apap_core_i (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_RATE_HZ(rate_hz),
		.I_PLAY_DATA(play_data), .I_PLAY_VALID(play_valid), .O_PLAY_READY(play_ready),
		.O_PWM(pwm), .I_BUZZ_EN(buzz_en), .I_BUZZ_HALF(buzz_half), .O_BUZZER(buzzer),
		.I_ADC_DATA(adc_data), .I_ADC_VALID(adc_valid), .O_ADC_READY(adc_ready),
		.I_VOLUME(volume), .I_GATE_LEVEL(gate_level), .O_ADPCM_DATA(adpcm_data),
		.O_ADPCM_VALID(adpcm_valid), .I_ADPCM_READY(adpcm_ready), .O_PERIOD(period),
		.O_ALC_GAIN(alc_gain));

	apap_speaker_model apap_speaker_model_i (.i_clk(clk), .i_pwm(pwm), .i_buzzer(buzzer),
		.o_high_len(high_len), .o_buzz_half(buzz_gap));

	always @(posedge clk) begin
		if (adpcm_valid === 1'b1 && adpcm_ready === 1'b1) begin
			last_word <= adpcm_data;
			n_words   <= n_words + 1;
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		if (errors == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ready is looked at on the falling edge so the outcome never hangs on process order
	task automatic push_play(input logic [15:0] d);
		@(posedge clk);
		play_valid <= 1'b1;
		play_data  <= d;
		do @(negedge clk); while (play_ready !== 1'b1);
		@(posedge clk);
		play_valid <= 1'b0;
	endtask

	task automatic push_adc(input logic [15:0] d);
		@(posedge clk);
		adc_valid <= 1'b1;
		adc_data  <= d;
		do @(negedge clk); while (adc_ready !== 1'b1);
		@(posedge clk);
		adc_valid <= 1'b0;
	endtask

	task automatic do_reset;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (14) @(posedge clk);
		@(negedge clk);
		check("pwm", pwm, 0);
		check("buzzer", buzzer, 0);
		check("play ready", play_ready, 1);
		check("adc ready", adc_ready, 1);
		check("adpcm valid", adpcm_valid, 0);
		check("period", period, 13'h1770);
		check("alc gain", alc_gain, 8'h80);
		@(posedge clk);
		rst_n <= 1'b1;
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		do_reset;
		// one sample per row, its width held over several periods by the modulator
		for (int i = 0; i < 6; i++) begin
			rate_hz <= ROWS[i][63:48];
			push_play(ROWS[i][47:32]);
			repeat (2 * prev + 3 * int'(ROWS[i][31:16]) + 100) @(posedge clk);
			check("period", period, ROWS[i][31:16]);
			check("width", high_len, ROWS[i][15:0]);
			prev = ROWS[i][31:16];
		end
		// a pulse end leaves over 2000 counts before the next period end, so the fifo cannot drain
		@(negedge pwm);
		n = 0;
		play_valid <= 1'b1;
		repeat (4) begin
			@(negedge clk);
			if (play_ready === 1'b1) n++;
			@(posedge clk);
		end
		check("play accepts", n, 2);
		// the refused word stays offered until a period end frees a slot
		do @(negedge clk); while (play_ready !== 1'b1);
		@(posedge clk);
		play_valid <= 1'b0;
		buzz_en <= 1'b1;
		repeat (40) @(posedge clk);
		check("buzz half", buzz_gap, 10);
		buzz_en <= 1'b0;
		repeat (2) @(posedge clk);
		check("buzz off", buzzer, 0);
		gate_level <= 16'h1000;
		push_adc(16'h0800);
		push_adc(16'hf800);
		push_adc(16'h0fff);
		push_adc(16'h0001);
		repeat (4) @(posedge clk);
		check("gated word", last_word, 16'h0919);
		gate_level <= 16'h0000;
		repeat (4) push_adc(16'h7000);
		repeat (4) @(posedge clk);
		check("alc down", alc_gain, 8'h7c);
		volume <= 8'h40;
		repeat (4) push_adc(16'h7000);
		repeat (4) @(posedge clk);
		check("alc held", alc_gain, 8'h7c);
		check("words", n_words, 3);
		// stalled reader: two words buffered plus one held in the packer
		n = 0;
		adpcm_ready <= 1'b0;
		adc_valid   <= 1'b1;
		adc_data    <= 16'h0100;
		repeat (16) begin
			@(negedge clk);
			if (adc_ready === 1'b1) n++;
			@(posedge clk);
		end
		adpcm_ready <= 1'b1;
		// the offered sample stays up until the packer frees a slot
		do @(negedge clk); while (adc_ready !== 1'b1);
		@(posedge clk);
		adc_valid   <= 1'b0;
		repeat (8) @(posedge clk);
		check("adc accepts", n, 12);
		check("words drained", n_words, 6);
		buzz_en <= 1'b1;
		rate_hz <= 16'hbb80;
		repeat (30) @(posedge clk);
		do_reset;
		report_and_stop;
	end

	initial begin
		repeat (90000) @(posedge clk);
		errors++;
		report_and_stop;
	end
endmodule
